//--- src/eipg_defines.vh
// constants for the event interrupt pulse generator
// Overview of operation
// [RULE_01] in normal or stop mode an event drives the output low about 100 us.
// [RULE_02] between two pulses the output stays high at least 100 us.
// [RULE_03] a pulse never changes the operating mode by itself.
// [RULE_04] the event output is push/pull, driven both high and low.
// [RULE_05] class bit 0 gives wake-only interrupts, 1 gives wake plus failures.
// [RULE_06] a latched wake event interrupts only if that source is wake-enabled.
// [RULE_07] global class adds failure flags; the wake level register never interrupts.
// [RULE_08] restart or fail-safe errors, power-on and device status bits never interrupt.
// [RULE_09] stop command accepted with wake status bits still set raises a pulse.
// [RULE_10] host-visible status registers are refreshed at each pulse falling edge.
// [RULE_11] events stay latched until the host reads and clears the register.
// [RULE_12] host should read the register again after clearing to confirm.
// [RULE_13] in init mode the event pin is an input that sets the configuration.
// [RULE_14] the configuration level is filtered about 7 us before being accepted.
// [RULE_15] an event during a pulse or the gap is signalled by a later pulse.
`ifndef EIPG_DEFINES_VH
`define EIPG_DEFINES_VH
`define EIPG_CLK_MHZ 100
`define EIPG_PULSE_US 100
`define EIPG_GAP_US 100
`define EIPG_CFG_FILT_US 7
`define EIPG_PULSE_CYC (`EIPG_PULSE_US * `EIPG_CLK_MHZ)
`define EIPG_GAP_CYC (`EIPG_GAP_US * `EIPG_CLK_MHZ)
`define EIPG_CFG_FILT_CYC (`EIPG_CFG_FILT_US * `EIPG_CLK_MHZ)
`define EIPG_ADR_WK1 4'h0
`define EIPG_ADR_WK2 4'h1
`define EIPG_ADR_LVL 4'h2
`define EIPG_ADR_FAIL 4'h3
`define EIPG_ADR_WKEN1 4'h4
`define EIPG_ADR_WKEN2 4'h5
`define EIPG_ADR_FAILEN 4'h6
`define EIPG_ADR_CTRL 4'h7
`define EIPG_ADR_STAT 4'h8
`define EIPG_CTRL_GLOBAL 0
`define EIPG_MODE_INIT 2'h0
`define EIPG_MODE_NORMAL 2'h1
`define EIPG_MODE_STOP 2'h2
`define EIPG_MODE_OTHER 2'h3
`endif

//--- src/eipg_top.v
// event interrupt pulse generator with wishbone status registers
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "eipg_defines.vh"
module eipg_top #(
    parameter PULSE_CYC = `EIPG_PULSE_CYC,
    parameter GAP_CYC = `EIPG_GAP_CYC,
    parameter FILT_CYC = `EIPG_CFG_FILT_CYC,
    parameter W = 8
) (
    input wire CLK,
    input wire RST,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [5:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    input wire [1:0] MODE,
    input wire STOP_CMD,
    input wire [W-1:0] WAKE_SET_ONE,
    input wire [W-1:0] WAKE_SET_TWO,
    input wire [W-1:0] WAKE_LEVEL,
    input wire [W-1:0] FAIL_SET,
    input wire [W-1:0] FAIL_NOINT,
    input wire EVENT_PIN_I,
    output reg EVENT_PIN_O,
    output wire EVENT_PIN_OE,
    output reg CONFIG_SEL,
    output reg CONFIG_VALID,
    output wire PULSE_ACTIVE
);
    localparam ST_IDLE = 2'h0;
    localparam ST_PULSE = 2'h1;
    localparam ST_GAP = 2'h2;

    reg [1:0] state;
    reg [15:0] cnt;
    reg [W-1:0] wake_status_one, wake_status_two, fail_status;
    reg [W-1:0] rd_wk1, rd_wk2, rd_lvl, rd_fail;
    reg [W-1:0] wk_en_one, wk_en_two, fail_en;
    reg class_global;
    reg pending;
    reg pin_s1, pin_s2;
    reg [15:0] fcnt;
    reg filt_lvl;
    reg [W-1:0] clr1, clr2, clrf;
    wire run_mode = (MODE == `EIPG_MODE_NORMAL) || (MODE == `EIPG_MODE_STOP);
    wire in_init = (MODE == `EIPG_MODE_INIT);
    wire wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    wire [3:0] idx = WB_ADR_I[5:2];
    // writes land on the ack edge, while the master still holds the request
    wire wr = WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I && WB_SEL_I[0];

    // [RULE_06] enabled wake sources
    wire wake_hit = |((WAKE_SET_ONE & wk_en_one) | (WAKE_SET_TWO & wk_en_two));
    // [RULE_07] failures only in global class
    // [RULE_08] non-interrupting flags excluded
    wire fail_hit = class_global && |(FAIL_SET & fail_en & ~FAIL_NOINT);
    // [RULE_09] stop entry with wake bits left
    wire stop_hit = STOP_CMD && (|wake_status_one || |wake_status_two);
    wire new_evt = wake_hit || fail_hit || stop_hit;

    // [RULE_04] push/pull: enabled outside init
    // [RULE_13] pin is input in init mode
    assign EVENT_PIN_OE = !in_init;
    assign PULSE_ACTIVE = (state == ST_PULSE);

    always @* begin
        clr1 = {W{1'b0}};
        clr2 = {W{1'b0}};
        clrf = {W{1'b0}};
        if (wr && idx == `EIPG_ADR_WK1)
            clr1 = WB_DAT_I[W-1:0];
        if (wr && idx == `EIPG_ADR_WK2)
            clr2 = WB_DAT_I[W-1:0];
        if (wr && idx == `EIPG_ADR_FAIL)
            clrf = WB_DAT_I[W-1:0];
    end

    // [RULE_11] sticky latch, set beats clear
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            wake_status_one <= {W{1'b0}};
            wake_status_two <= {W{1'b0}};
            fail_status <= {W{1'b0}};
        end else begin
            wake_status_one <= (wake_status_one & ~clr1) | (WAKE_SET_ONE & wk_en_one);
            wake_status_two <= (wake_status_two & ~clr2) | (WAKE_SET_TWO & wk_en_two);
            fail_status <= (fail_status & ~clrf) | (FAIL_SET & ~FAIL_NOINT);
        end
    end

    // [RULE_01] pulse and gap sequencer
    // [RULE_03] mode is only an input here
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            state <= ST_IDLE;
            cnt <= 16'h0000;
            pending <= 1'b0;
            EVENT_PIN_O <= 1'b1;
            rd_wk1 <= {W{1'b0}};
            rd_wk2 <= {W{1'b0}};
            rd_lvl <= {W{1'b0}};
            rd_fail <= {W{1'b0}};
        end else begin
            // [RULE_11] a clear also empties the read copy
            rd_wk1 <= rd_wk1 & ~clr1;
            rd_wk2 <= rd_wk2 & ~clr2;
            rd_fail <= rd_fail & ~clrf;
            // [RULE_15] remember events while busy
            if (new_evt && run_mode && state != ST_IDLE)
                pending <= 1'b1;
            case (state)
                ST_IDLE: begin
                    EVENT_PIN_O <= 1'b1;
                    if (run_mode && (new_evt || pending)) begin
                        state <= ST_PULSE;
                        cnt <= 16'h0000;
                        pending <= 1'b0;
                        EVENT_PIN_O <= 1'b0;
                        // [RULE_10] snapshot at falling edge
                        rd_wk1 <= wake_status_one | (WAKE_SET_ONE & wk_en_one);
                        rd_wk2 <= wake_status_two | (WAKE_SET_TWO & wk_en_two);
                        rd_lvl <= WAKE_LEVEL;
                        rd_fail <= fail_status | (FAIL_SET & ~FAIL_NOINT);
                    end
                end
                ST_PULSE: begin
                    if (cnt == PULSE_CYC - 1) begin
                        state <= ST_GAP;
                        cnt <= 16'h0000;
                        EVENT_PIN_O <= 1'b1;
                    end else
                        cnt <= cnt + 16'h0001;
                end
                ST_GAP: begin
                    // [RULE_02] enforce minimum high gap
                    if (cnt == GAP_CYC - 1) begin
                        state <= ST_IDLE;
                        cnt <= 16'h0000;
                    end else
                        cnt <= cnt + 16'h0001;
                end
                default: begin
                    state <= ST_IDLE;
                    EVENT_PIN_O <= 1'b1;
                end
            endcase
        end
    end

    // pin sampling crosses from the outside world
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
        end else begin
            pin_s1 <= EVENT_PIN_I;
            pin_s2 <= pin_s1;
        end
    end

    // [RULE_14] configuration level filter
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            fcnt <= 16'h0000;
            filt_lvl <= 1'b0;
            CONFIG_SEL <= 1'b0;
            CONFIG_VALID <= 1'b0;
        end else if (in_init) begin
            if (pin_s2 != filt_lvl) begin
                filt_lvl <= pin_s2;
                fcnt <= 16'h0000;
            end else if (fcnt == FILT_CYC - 1) begin
                CONFIG_SEL <= filt_lvl;
                CONFIG_VALID <= 1'b1;
            end else
                fcnt <= fcnt + 16'h0001;
        end
    end

    // register writes: enables and class select
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            wk_en_one <= {W{1'b0}};
            wk_en_two <= {W{1'b0}};
            fail_en <= {W{1'b0}};
            // [RULE_05] default is wake-only class
            class_global <= 1'b0;
        end else if (wr) begin
            case (idx)
                `EIPG_ADR_WKEN1: wk_en_one <= WB_DAT_I[W-1:0];
                `EIPG_ADR_WKEN2: wk_en_two <= WB_DAT_I[W-1:0];
                `EIPG_ADR_FAILEN: fail_en <= WB_DAT_I[W-1:0];
                `EIPG_ADR_CTRL: class_global <= WB_DAT_I[`EIPG_CTRL_GLOBAL];
                default: class_global <= class_global;
            endcase
        end
    end

    // one-wait wishbone slave; unmapped reads return zero
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
        end else begin
            WB_ACK_O <= wb_req;
            WB_DAT_O <= 32'h00000000;
            if (wb_req && !WB_WE_I) begin
                case (idx)
                    `EIPG_ADR_WK1: WB_DAT_O[W-1:0] <= rd_wk1;
                    `EIPG_ADR_WK2: WB_DAT_O[W-1:0] <= rd_wk2;
                    `EIPG_ADR_LVL: WB_DAT_O[W-1:0] <= rd_lvl;
                    `EIPG_ADR_FAIL: WB_DAT_O[W-1:0] <= rd_fail;
                    `EIPG_ADR_WKEN1: WB_DAT_O[W-1:0] <= wk_en_one;
                    `EIPG_ADR_WKEN2: WB_DAT_O[W-1:0] <= wk_en_two;
                    `EIPG_ADR_FAILEN: WB_DAT_O[W-1:0] <= fail_en;
                    `EIPG_ADR_CTRL: WB_DAT_O[0] <= class_global;
                    `EIPG_ADR_STAT: WB_DAT_O[5:0] <= {CONFIG_VALID, CONFIG_SEL, pending,
                        EVENT_PIN_O, state};
                    default: WB_DAT_O <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

//--- tb/eipg_chk.sv
// assertion checker for the event pin and bus
`timescale 1ns/100ps
module eipg_chk #(parameter PULSE_CYC = 20, parameter GAP_CYC = 20, parameter FILT_CYC = 8) (
    input wire CLK,
    input wire RST,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_ACK_O,
    input wire [1:0] MODE,
    input wire EVENT_PIN_I,
    input wire EVENT_PIN_O,
    input wire EVENT_PIN_OE,
    input wire CONFIG_VALID
);
    reg [7:0] lo_cnt;
    reg [7:0] hi_cnt;
    reg [7:0] st_cnt;
    reg pin_d;
    // counters saturate so long idle spans cannot wrap
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            lo_cnt <= 8'h00;
            hi_cnt <= 8'hff;
            st_cnt <= 8'h00;
            pin_d <= 1'b0;
        end else begin
            lo_cnt <= EVENT_PIN_O ? 8'h00 : lo_cnt + {7'h0, lo_cnt != 8'hff};
            hi_cnt <= EVENT_PIN_O ? hi_cnt + {7'h0, hi_cnt != 8'hff} : 8'h00;
            st_cnt <= (EVENT_PIN_I != pin_d) ? 8'h00 : st_cnt + {7'h0, st_cnt != 8'hff};
            pin_d <= EVENT_PIN_I;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    property p_pulse_len; $rose(EVENT_PIN_O) |-> lo_cnt == PULSE_CYC; endproperty
    property p_gap_len; $fell(EVENT_PIN_O) |-> hi_cnt >= GAP_CYC; endproperty
    property p_gap_hold; $rose(EVENT_PIN_O) |=> EVENT_PIN_O [*8]; endproperty
    property p_drive; EVENT_PIN_OE == (MODE != 2'h0); endproperty
    property p_no_init; $fell(EVENT_PIN_O) |-> $past(MODE) != 2'h0; endproperty
    property p_cfg; $rose(CONFIG_VALID) |-> st_cnt >= FILT_CYC; endproperty
    property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
    property p_ack_one; WB_ACK_O |=> !WB_ACK_O; endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pulse width wrong");
    a_gap_len: assert property (p_gap_len) else $error("gap too short");
    a_gap_hold: assert property (p_gap_hold) else $error("gap broken");
    a_drive: assert property (p_drive) else $error("pin enable wrong");
    a_no_init: assert property (p_no_init) else $error("pulse in init");
    a_cfg: assert property (p_cfg) else $error("config not filtered");
    a_ack: assert property (p_ack) else $error("no ack");
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    c_pulse: cover property ($fell(EVENT_PIN_O));
    c_gap: cover property ($rose(EVENT_PIN_O));
    c_cfg: cover property ($rose(CONFIG_VALID));
endmodule

//--- tb/eipg_host.sv
// host model: pin wire with config strap, pulse counter
`timescale 1ns/100ps
module eipg_host #(parameter bit CFG_LVL = 1'b1) (
    input wire CLK,
    input wire dev_o,
    input wire dev_oe,
    output wire pin,
    output integer pulse_cnt
);
    reg pin_d = 1'b1;
    assign pin = dev_oe ? dev_o : CFG_LVL;
    initial pulse_cnt = 0;
    always @(posedge CLK) begin
        pin_d <= pin;
        if (pin_d && !pin)
            pulse_cnt <= pulse_cnt + 1;
    end
endmodule

//--- tb/eipg_top_test.sv
// self-checking bench for the event pulse generator
`timescale 1ns/100ps
module eipg_top_test;
    typedef struct packed {logic cls; logic [1:0] src; logic [7:0] en, noint, v; logic exp;} eipg_row;
    eipg_row rows [7] = '{'{1'b0, 2'h0, 8'h01, 8'h00, 8'h01, 1'b1},
        '{1'b0, 2'h0, 8'h00, 8'h00, 8'h02, 1'b0}, '{1'b0, 2'h1, 8'h08, 8'h00, 8'h08, 1'b1},
        '{1'b0, 2'h2, 8'hff, 8'h00, 8'h04, 1'b0}, '{1'b1, 2'h2, 8'hff, 8'h00, 8'h04, 1'b1},
        '{1'b1, 2'h2, 8'hff, 8'h04, 8'h04, 1'b0}, '{1'b1, 2'h3, 8'hff, 8'h00, 8'hff, 1'b0}};
    logic clk, rst, cyc, stb, we, stop;
    logic [5:0] adr;
    logic [31:0] dat, q;
    logic [1:0] mode;
    logic [7:0] wk1, wk2, fl, lvl, noint;
    wire [31:0] rdat;
    wire ack, pin_o, pin_oe, pin, cfg_sel, cfg_ok, pact;
    integer err_total = 0, total_checks = 0, pulses, n0;
    eipg_top #(.PULSE_CYC(20), .GAP_CYC(20), .FILT_CYC(8)) u_dut (.CLK(clk), .RST(rst),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
        .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .MODE(mode), .STOP_CMD(stop),
        .WAKE_SET_ONE(wk1), .WAKE_SET_TWO(wk2), .WAKE_LEVEL(lvl), .FAIL_SET(fl),
        .FAIL_NOINT(noint), .EVENT_PIN_I(pin), .EVENT_PIN_O(pin_o), .EVENT_PIN_OE(pin_oe),
        .CONFIG_SEL(cfg_sel), .CONFIG_VALID(cfg_ok), .PULSE_ACTIVE(pact));
    eipg_host u_host (.CLK(clk), .dev_o(pin_o), .dev_oe(pin_oe), .pin(pin), .pulse_cnt(pulses));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
        // no local limit: a missing ack is left to the watchdog
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'h0;
    endtask
    task evt(input logic [1:0] s, input logic [7:0] v);
        {wk1, wk2, fl, lvl} <= {v, 24'h0} >> (8 * s);
        @(posedge clk);
        {wk1, wk2, fl, lvl} <= 32'h0;
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        print_verdict;
    end
    initial begin
        {cyc, stb, we, stop, adr, dat, wk1, wk2, fl, lvl, noint} = 0;
        mode = 2'h0;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        chk("pin and enable", 32'h2, {30'h0, pin_o, pin_oe});
        rst <= 1'b0;
        repeat (30) @(posedge clk);
        chk("config", 32'h3, {30'h0, cfg_ok, cfg_sel});
        $display("reset and config done");
        mode <= 2'h1;
        foreach (rows[i]) begin
            n0 = pulses;
            // clears first so old latches cannot fire once enabled
            for (int a = 0; a < 7; a++)
                wb(1'b1, 6'(a * 4), a < 4 ? 32'hff : {24'h0, rows[i].en});
            wb(1'b1, 6'h1c, {31'h0, rows[i].cls});
            noint <= rows[i].noint;
            evt(rows[i].src, rows[i].v);
            repeat (50) @(posedge clk);
            chk("pulses", {31'h0, rows[i].exp}, pulses - n0);
            $display("row %0d done", i);
        end
        n0 = pulses;
        evt(2'h0, 8'h10);
        repeat (5) @(posedge clk);
        chk("active", 32'h3, {30'h0, pact, ~pin_o});
        evt(2'h0, 8'h20);
        repeat (70) @(posedge clk);
        chk("pending", 2, pulses - n0);
        wb(1'b0, 6'h00, 32'h0);
        chk("snapshot", 32'h30, q);
        $display("pending and snapshot done");
        n0 = pulses;
        mode <= 2'h2;
        stop <= 1'b1;
        @(posedge clk);
        stop <= 1'b0;
        repeat (30) @(posedge clk);
        chk("stop pulse", 1, pulses - n0);
        $display("stop done");
        wb(1'b1, 6'h00, 32'hff);
        // read back after the clear to confirm
        wb(1'b0, 6'h00, 32'h0);
        chk("cleared", 0, q);
        wb(1'b0, 6'h3c, 32'h0);
        chk("unmapped", 0, q);
        $display("clear done");
        // the other mode (2'h3), neither normal nor stop, must stay silent
        n0 = pulses;
        mode <= 2'h3;
        evt(2'h0, 8'h40);
        repeat (50) @(posedge clk);
        chk("other mode", 0, pulses - n0);
        $display("other mode done");
        // reset in mid-pulse must release the pin at once
        mode <= 2'h1;
        evt(2'h0, 8'h40);
        repeat (3) @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        chk("reset pin", 32'h2, {30'h0, pin_o, pact});
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        wb(1'b0, 6'h10, 32'h0);
        chk("enable after reset", 0, q);
        $display("mid-run reset done");
        $display("hand tests done");
        print_verdict;
    end
endmodule
bind eipg_top eipg_chk #(.PULSE_CYC(PULSE_CYC), .GAP_CYC(GAP_CYC), .FILT_CYC(FILT_CYC)) u_chk (
    .CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
    .MODE(MODE), .EVENT_PIN_I(EVENT_PIN_I), .EVENT_PIN_O(EVENT_PIN_O),
    .EVENT_PIN_OE(EVENT_PIN_OE), .CONFIG_VALID(CONFIG_VALID));
